// ---- rtl/qasp_map.svh ----
// constants for the quad async serial ports: timing, widths, pin routing
`ifndef QASP_MAP_SVH
`define QASP_MAP_SVH
`define QASP_CLK_HZ 50000000
`define QASP_BAUD_MIN 300
`define QASP_BAUD_MAX 600000
`define QASP_OVERSAMPLE 16
`define QASP_DATA_BITS 8
`define QASP_NUM_PORTS 4
`define QASP_NUM_GPIO 16
`define QASP_GPIO_SEL_W 4
`define QASP_DIV_W 16
// divider: clocks per oversample tick
`define QASP_DIV_FOR(b) ((`QASP_CLK_HZ) / ((b) * `QASP_OVERSAMPLE))
`define QASP_DIV_DEFAULT 16'd27
`define QASP_RST_DIV 16'd27
`endif

// ---- rtl/qasp_pkg.sv ----
// types shared by the serial port ends
package qasp_pkg;
  typedef enum logic [3:0] {
    QASP_IDLE = 4'b0001,
    QASP_START = 4'b0010,
    QASP_DATA = 4'b0100,
    QASP_STOP = 4'b1000
  } qasp_state_e;
  typedef logic [7:0] qasp_byte_t;
endpackage

// ---- rtl/qasp_link_if.sv ----
// serial lines between device ports and the attached party
interface qasp_link_if;
  logic dedicatedTxd;
  logic dedicatedRxd;
  logic [15:0] gpioOut;
  logic [15:0] gpioOutEn_n;
  logic [15:0] gpioIn;
  modport device (output dedicatedTxd, input dedicatedRxd, output gpioOut, output gpioOutEn_n,
    input gpioIn);
  modport party (input dedicatedTxd, output dedicatedRxd, input gpioOut, input gpioOutEn_n,
    output gpioIn);
endinterface

// ---- rtl/qasp_uart_core.sv ----
// one full-duplex 8n1 serial channel with oversampling receiver
`include "qasp_map.svh"
module qasp_uart_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [15:0] baudDiv,
  // transmit request
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  // receive result
  output logic [7:0] rxData,
  output logic rxStrobe,
  output logic rxFrameErr,
  // serial lines
  input wire logic rxd,
  output logic txd
);
  ////////////////////////////////////////////////////////////////
  logic [15:0] tickCnt;
  logic tick;
  logic rxMeta;
  logic rxSync;
  qasp_pkg::qasp_state_e txState;
  qasp_pkg::qasp_state_e rxState;
  logic [3:0] txPhase;
  logic [2:0] txBit;
  logic [7:0] txShift;
  logic [3:0] rxPhase;
  logic [2:0] rxBit;
  logic [7:0] rxShift;
  wire divZero = (baudDiv == 16'h0000);
  wire phaseEnd = (txPhase == 4'hf);
  wire rxMid = (rxPhase == 4'h7);
  wire rxEnd = (rxPhase == 4'hf);
  assign txReady = (txState == qasp_pkg::QASP_IDLE);
  // oversample tick; divisor zero parks the channel
  always_ff @(posedge core_clk) begin
    if (sys_rst || divZero || tickCnt == 16'h0000) begin
      tickCnt <= baudDiv - 16'h0001;
    end else begin
      tickCnt <= tickCnt - 16'h0001;
    end
  end
  assign tick = !divZero && (tickCnt == 16'h0000);
  // receive pin crosses two flops before any logic sees it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxd;
      rxSync <= rxMeta;
    end
  end
  ////////////////////////////////////////////////////////////////
  // transmitter: start 0, data lsb first, stop 1, idle high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txState <= qasp_pkg::QASP_IDLE;
      txd <= 1'b1;
      txPhase <= 4'h0;
      txBit <= 3'h0;
      txShift <= 8'h00;
    end else begin
      case (txState)
        qasp_pkg::QASP_IDLE: begin
          txd <= 1'b1;
          txPhase <= 4'h0;
          if (txValid) begin
            txShift <= txData;
            txState <= qasp_pkg::QASP_START;
          end
        end
        qasp_pkg::QASP_START: begin
          if (tick) begin
            txd <= 1'b0;
            txPhase <= txPhase + 4'h1;
            if (phaseEnd) begin
              txState <= qasp_pkg::QASP_DATA;
              txBit <= 3'h0;
            end
          end
        end
        qasp_pkg::QASP_DATA: begin
          if (tick) begin
            txd <= txShift[txBit];
            txPhase <= txPhase + 4'h1;
            if (phaseEnd) begin
              txBit <= txBit + 3'h1;
              if (txBit == 3'h7) begin
                txState <= qasp_pkg::QASP_STOP;
              end
            end
          end
        end
        qasp_pkg::QASP_STOP: begin
          if (tick) begin
            txd <= 1'b1;
            txPhase <= txPhase + 4'h1;
            if (phaseEnd) begin
              txState <= qasp_pkg::QASP_IDLE;
            end
          end
        end
        default: txState <= qasp_pkg::QASP_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // receiver: falling edge, confirm at mid start, sample centres
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxState <= qasp_pkg::QASP_IDLE;
      rxPhase <= 4'h0;
      rxBit <= 3'h0;
      rxShift <= 8'h00;
      rxData <= 8'h00;
      rxStrobe <= 1'b0;
      rxFrameErr <= 1'b0;
    end else begin
      rxStrobe <= 1'b0;
      case (rxState)
        qasp_pkg::QASP_IDLE: begin
          rxPhase <= 4'h0;
          if (tick && !rxSync) begin
            rxState <= qasp_pkg::QASP_START;
          end
        end
        qasp_pkg::QASP_START: begin
          if (tick) begin
            rxPhase <= rxPhase + 4'h1;
            if (rxMid && rxSync) begin
              rxState <= qasp_pkg::QASP_IDLE;
            end else if (rxEnd) begin
              rxState <= qasp_pkg::QASP_DATA;
              rxBit <= 3'h0;
            end
          end
        end
        qasp_pkg::QASP_DATA: begin
          if (tick) begin
            rxPhase <= rxPhase + 4'h1;
            if (rxMid) begin
              rxShift <= {rxSync, rxShift[7:1]};
            end
            if (rxEnd) begin
              rxBit <= rxBit + 3'h1;
              if (rxBit == 3'h7) begin
                rxState <= qasp_pkg::QASP_STOP;
              end
            end
          end
        end
        qasp_pkg::QASP_STOP: begin
          if (tick && rxMid) begin
            rxData <= rxShift;
            rxStrobe <= 1'b1;
            rxFrameErr <= !rxSync;
            rxState <= qasp_pkg::QASP_IDLE;
          end else if (tick) begin
            rxPhase <= rxPhase + 4'h1;
          end
        end
        default: rxState <= qasp_pkg::QASP_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/qasp_device.sv ----
// device end: dedicated port plus three pin-routable ports
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "qasp_map.svh"
// Notes on behaviour
// - one fixed port, three routable ports
// - dedicated port pins are never rerouted
// - routable tx and rx each one pin
// - each port full duplex, eight bits
// - frame is 8 data, no parity, 1 stop
// - per-port baud divisor, 300 to 600K
// - single-byte mode, one character per request
// - buffered mode stores received bytes autonomously
// - start, eight data bits, then stop
// - start bit zero, stop bit one
// - data sent least significant bit first
// - only dedicated port carries download traffic
// - running application releases dedicated port
// - party crosses its tx and rx lines
// - a signal maps to one pin only
module qasp_device #(
  parameter int BUF_DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial link
  qasp_link_if.device link,
  // software register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // download engine side of the dedicated port
  input wire logic appRunning,
  output logic [7:0] dlData,
  output logic dlStrobe
);
  ////////////////////////////////////////////////////////////////
  localparam int PW = $clog2(BUF_DEPTH);
  // pointer wrap logic only serves power-of-two depths
  if (BUF_DEPTH < 2 || (1 << PW) != BUF_DEPTH) begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two of at least 2");
  end
  // register map: addr[4:2]=port, addr[1:0]=register
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_BAUD = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;
  logic [15:0] baudDiv [4];
  logic bufMode [4];
  logic [3:0] txPinSel [4];
  logic [3:0] rxPinSel [4];
  logic txPinEn [4];
  logic rxPinEn [4];
  logic [7:0] rxHold [4];
  logic rxAvail [4];
  logic frameErr [4];
  logic overrun [4];
  logic [7:0] bufMem [4][BUF_DEPTH];
  logic [PW:0] wrPtr [4];
  logic [PW:0] rdPtr [4];
  logic [7:0] txHold [4];
  logic txPend [4];
  logic txReady [4];
  logic [7:0] rxData [4];
  logic rxStrobe [4];
  logic rxFrameErr [4];
  logic portRxd [4];
  logic portTxd [4];
  logic [15:0] gpioSync1;
  logic [15:0] gpioSync2;
  wire [2:0] selPort = regAddr[4:2];
  wire [1:0] selReg = regAddr[1:0];
  wire addrOk = (selPort < 3'd4);
  ////////////////////////////////////////////////////////////////
  // gpio inputs pass two flops before routing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gpioSync1 <= 16'hffff;
      gpioSync2 <= 16'hffff;
    end else begin
      gpioSync1 <= link.gpioIn;
      gpioSync2 <= gpioSync1;
    end
  end
  // the dedicated port is hard wired; its rx is raw so the core syncs it
  assign link.dedicatedTxd = portTxd[0];
  assign portRxd[0] = link.dedicatedRxd;
  // routed ports take one selected pin each, idle high when unrouted
  for (genvar p = 1; p < 4; p++) begin : g_rx
    assign portRxd[p] = rxPinEn[p] ? gpioSync2[rxPinSel[p]] : 1'b1;
  end
  // each pin driven by the lowest routed port; one select per signal
  always_comb begin
    link.gpioOut = 16'hffff;
    link.gpioOutEn_n = 16'hffff;
    for (int p = 3; p >= 1; p--) begin
      if (txPinEn[p]) begin
        link.gpioOut[txPinSel[p]] = portTxd[p];
        link.gpioOutEn_n[txPinSel[p]] = 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // four identical channels
  for (genvar p = 0; p < 4; p++) begin : g_port
    qasp_uart_core u_core (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .baudDiv(baudDiv[p]),
      .txValid(txPend[p]),
      .txData(txHold[p]),
      .txReady(txReady[p]),
      .rxData(rxData[p]),
      .rxStrobe(rxStrobe[p]),
      .rxFrameErr(rxFrameErr[p]),
      .rxd(portRxd[p]),
      .txd(portTxd[p])
    );
  end
  // download traffic only from the dedicated port until the app runs
  wire dlOwns = !appRunning;
  assign dlData = rxData[0];
  assign dlStrobe = rxStrobe[0] && dlOwns;
  ////////////////////////////////////////////////////////////////
  // per-port register state, receive capture and buffering
  for (genvar p = 0; p < 4; p++) begin : g_regs
    wire hit = addrOk && (selPort == 3'(p));
    wire userRx = rxStrobe[p] && (p != 0 || !dlOwns);
    wire bufFull = (wrPtr[p] ^ rdPtr[p]) == {1'b1, {PW{1'b0}}};
    wire bufEmpty = (wrPtr[p] == rdPtr[p]);
    wire readData = regRd && hit && (selReg == REG_DATA);
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        baudDiv[p] <= `QASP_RST_DIV;
        bufMode[p] <= 1'b0;
        txPinSel[p] <= 4'h0;
        rxPinSel[p] <= 4'h0;
        txPinEn[p] <= 1'b0;
        rxPinEn[p] <= 1'b0;
        txPend[p] <= 1'b0;
        txHold[p] <= 8'h00;
        rxHold[p] <= 8'h00;
        rxAvail[p] <= 1'b0;
        frameErr[p] <= 1'b0;
        overrun[p] <= 1'b0;
        wrPtr[p] <= '0;
        rdPtr[p] <= '0;
      end else begin
        if (txPend[p] && txReady[p]) begin
          txPend[p] <= 1'b0;
        end
        if (regWr && hit) begin
          case (selReg)
            REG_DATA: begin
              if (!txPend[p]) begin
                txHold[p] <= regWdata[7:0];
                txPend[p] <= 1'b1;
              end
            end
            REG_STAT: begin
              frameErr[p] <= regWdata[2] ? 1'b0 : frameErr[p];
              overrun[p] <= regWdata[3] ? 1'b0 : overrun[p];
            end
            REG_BAUD: baudDiv[p] <= regWdata;
            default: begin
              bufMode[p] <= regWdata[0];
              if (p != 0) begin
                txPinSel[p] <= regWdata[7:4];
                txPinEn[p] <= regWdata[8];
                rxPinSel[p] <= regWdata[12:9];
                rxPinEn[p] <= regWdata[13];
              end
            end
          endcase
        end
        // single-byte holding register consumed by a data read
        if (readData && !bufMode[p]) begin
          rxAvail[p] <= 1'b0;
        end
        if (readData && bufMode[p] && !bufEmpty) begin
          rdPtr[p] <= rdPtr[p] + 1'b1;
        end
        // set wins over software clear
        if (userRx) begin
          if (rxFrameErr[p]) begin
            frameErr[p] <= 1'b1;
          end
          if (bufMode[p]) begin
            if (!bufFull) begin
              bufMem[p][wrPtr[p][PW-1:0]] <= rxData[p];
              wrPtr[p] <= wrPtr[p] + 1'b1;
            end else begin
              overrun[p] <= 1'b1;
            end
          end else begin
            rxHold[p] <= rxData[p];
            rxAvail[p] <= 1'b1;
            if (rxAvail[p] && !readData) begin
              overrun[p] <= 1'b1;
            end
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe
  logic [PW:0] rp;
  logic [PW:0] wp;
  always_comb begin
    rp = rdPtr[selPort[1:0]];
    wp = wrPtr[selPort[1:0]];
  end
  wire bufHas = (rp != wp);
  wire curMode = bufMode[selPort[1:0]];
  wire haveByte = curMode ? bufHas : rxAvail[selPort[1:0]];
  wire [7:0] curByte = curMode ? bufMem[selPort[1:0]][rp[PW-1:0]] : rxHold[selPort[1:0]];
  wire [15:0] statWord = {12'h000, overrun[selPort[1:0]], frameErr[selPort[1:0]],
    haveByte, !txPend[selPort[1:0]]};
  wire [15:0] ctrlWord = {2'b00, rxPinEn[selPort[1:0]], rxPinSel[selPort[1:0]],
    txPinEn[selPort[1:0]], txPinSel[selPort[1:0]], 3'b000, curMode};
  always_ff @(posedge core_clk) begin
    if (sys_rst || !regRd || !addrOk) begin
      regRdata <= 16'h0000;
    end else begin
      case (selReg)
        REG_DATA: regRdata <= {8'h00, curByte};
        REG_STAT: regRdata <= statWord;
        REG_BAUD: regRdata <= baudDiv[selPort[1:0]];
        default: regRdata <= ctrlWord;
      endcase
    end
  end
endmodule

// ---- rtl/qasp_party.sv ----
// attached party end: one serial channel per device port
`include "qasp_map.svh"
module qasp_party #(
  parameter logic [3:0] A_TX_PIN = 4'h0,
  parameter logic [3:0] A_RX_PIN = 4'h1,
  parameter logic [3:0] B_TX_PIN = 4'h2,
  parameter logic [3:0] B_RX_PIN = 4'h3,
  parameter logic [3:0] C_TX_PIN = 4'h4,
  parameter logic [3:0] C_RX_PIN = 4'h5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial link
  qasp_link_if.party link,
  // per-channel user side, index 0 = dedicated port
  input wire logic [15:0] baudDiv [4],
  input wire logic txValid [4],
  input wire logic [7:0] txData [4],
  output logic txReady [4],
  output logic [7:0] rxData [4],
  output logic rxStrobe [4],
  output logic rxFrameErr [4]
);
  ////////////////////////////////////////////////////////////////
  // device tx pins feed our rx, our tx drives device rx pins
  logic pRxd [4];
  logic pTxd [4];
  assign pRxd[0] = link.dedicatedTxd;
  assign pRxd[1] = link.gpioOut[A_TX_PIN];
  assign pRxd[2] = link.gpioOut[B_TX_PIN];
  assign pRxd[3] = link.gpioOut[C_TX_PIN];
  assign link.dedicatedRxd = pTxd[0];
  always_comb begin
    link.gpioIn = 16'hffff;
    link.gpioIn[A_RX_PIN] = pTxd[1];
    link.gpioIn[B_RX_PIN] = pTxd[2];
    link.gpioIn[C_RX_PIN] = pTxd[3];
  end
  for (genvar p = 0; p < 4; p++) begin : g_ch
    qasp_uart_core u_core (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .baudDiv(baudDiv[p]),
      .txValid(txValid[p]),
      .txData(txData[p]),
      .txReady(txReady[p]),
      .rxData(rxData[p]),
      .rxStrobe(rxStrobe[p]),
      .rxFrameErr(rxFrameErr[p]),
      .rxd(pRxd[p]),
      .txd(pTxd[p])
    );
  end
endmodule

// ---- test/qasp_link_properties.sv ----
// concurrent checks on the serial link joining device and party
module qasp_link_properties #(
  parameter int BIT_CLKS = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // link signals
  input wire logic dedicatedTxd,
  input wire logic dedicatedRxd,
  input wire logic [15:0] gpioOut,
  input wire logic [15:0] gpioOutEn_n,
  input wire logic [15:0] gpioIn
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STOP_FIRST = 9 * BIT_CLKS;
  localparam int FRAME_LAST = 10 * BIT_CLKS - 1;
  logic txOpen;
  logic rxOpen;
  int txPos;
  int rxPos;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // frame position: a low sample on an idle line opens a frame
  always_ff @(posedge core_clk) begin
    if (sys_rst || (txOpen && txPos == FRAME_LAST)) begin
      txOpen <= 1'b0;
      txPos <= 1;
    end else begin
      txOpen <= txOpen || !dedicatedTxd;
      txPos <= txOpen ? txPos + 1 : 1;
    end
  end
  // same tracking for the party's transmit line
  always_ff @(posedge core_clk) begin
    if (sys_rst || (rxOpen && rxPos == FRAME_LAST)) begin
      rxOpen <= 1'b0;
      rxPos <= 1;
    end else begin
      rxOpen <= rxOpen || !dedicatedRxd;
      rxPos <= rxOpen ? rxPos + 1 : 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  // frame steps seen on the device transmit line
  sequence s_tx_open;
    !txOpen && !dedicatedTxd;
  endsequence
  sequence s_tx_stop;
    dedicatedTxd [*8];
  endsequence
  // reset must leave lines idle and pins released, not held off
  AST_LINES_IDLE_IN_RESET: assert property (disable iff (1'b0)
    sys_rst |=> dedicatedTxd && dedicatedRxd)
    else $error("serial line not idle after reset");
  AST_PINS_FREE_IN_RESET: assert property (disable iff (1'b0) sys_rst |=> &gpioOutEn_n)
    else $error("pin driven after reset");
  AST_UNDRIVEN_PINS_HIGH: assert property (&(gpioOut | ~gpioOutEn_n))
    else $error("released pin not high");
  AST_ONE_PIN_EACH: assert property ($countones(~gpioOutEn_n) <= 3)
    else $error("more pins driven than routed transmitters");
  AST_TX_START_LOW: assert property (txOpen && txPos < BIT_CLKS |-> !dedicatedTxd)
    else $error("device start bit not a full low bit");
  AST_TX_STOP_HIGH: assert property (s_tx_open |-> ##STOP_FIRST s_tx_stop)
    else $error("device stop bit not high after eight data bits");
  AST_TX_BIT_HOLD: assert property (txOpen && (txPos % BIT_CLKS) != 0
    |-> $stable(dedicatedTxd))
    else $error("device line moved inside a bit");
  AST_RX_START_LOW: assert property (rxOpen && rxPos < BIT_CLKS |-> !dedicatedRxd)
    else $error("party start bit not a full low bit");
  AST_RX_STOP_HIGH: assert property (rxOpen && rxPos >= STOP_FIRST |-> dedicatedRxd)
    else $error("party stop bit not high");
  AST_RX_BIT_HOLD: assert property (rxOpen && (rxPos % BIT_CLKS) != 0
    |-> $stable(dedicatedRxd))
    else $error("party line moved inside a bit");
endmodule

// ---- test/quad_async_serial_ports_tb_top.sv ----
// self-checking bench: device and party joined over the serial link
module quad_async_serial_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 32;
  localparam logic [3:0] PIN [4] = '{4'h0, 4'h0, 4'h7, 4'hc};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic appRunning = 1'b0;
  logic [15:0] regRdata;
  logic [15:0] regRdata2;
  logic [7:0] dlData;
  logic dlStrobe;
  logic [15:0] baudDiv [4];
  logic txValid [4];
  logic [7:0] txData [4];
  logic txReady [4];
  logic [7:0] rxData [4];
  logic rxStrobe [4];
  logic rxFrameErr [4];
  logic got [4];
  logic [7:0] gotData [4];
  logic [7:0] b [4];
  logic [7:0] c [4];
  logic [7:0] vals [3];
  logic [7:0] v;
  logic [9:0] f;
  logic [15:0] rd;
  logic [15:0] rd2;
  int n;
  int failures = 0;
  int checks = 0;
  qasp_link_if link ();
  qasp_link_if link2 ();
  qasp_device qasp_device_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.device),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .appRunning(appRunning), .dlData(dlData), .dlStrobe(dlStrobe));
  // second device on its own link, fed bench-made frames, one of them with a zero stop bit
  qasp_device qasp_device_inst2 (.core_clk(core_clk), .sys_rst(sys_rst), .link(link2.device),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata2),
    .appRunning(appRunning), .dlData(), .dlStrobe());
  // port a transmit stays on the party's default pin, which matches PIN[1]
  qasp_party #(.A_RX_PIN(PIN[1]), .B_TX_PIN(PIN[2]), .B_RX_PIN(PIN[2]), .C_TX_PIN(PIN[3]),
    .C_RX_PIN(PIN[3])) qasp_party_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link.party), .baudDiv(baudDiv), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxData(rxData), .rxStrobe(rxStrobe), .rxFrameErr(rxFrameErr));
  qasp_link_properties #(.BIT_CLKS(BIT)) qasp_link_properties_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .dedicatedTxd(link.dedicatedTxd), .dedicatedRxd(link.dedicatedRxd),
    .gpioOut(link.gpioOut), .gpioOutEn_n(link.gpioOutEn_n), .gpioIn(link.gpioIn));
  ////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // latch party receive pulses so the main flow can poll them
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (rxStrobe[i] === 1'b1) begin
        got[i] <= 1'b1;
        gotData[i] <= rxData[i];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // expected values and addressing
  function automatic logic [4:0] ad(input int p, input int r);
    return {p[2:0], r[1:0]};
  endfunction
  function automatic logic [15:0] div_of(input int p);
    return (p == 3) ? 16'h0003 : 16'h0002;
  endfunction
  function automatic logic [15:0] ctrl_of(input int p);
    return {2'b00, 1'b1, PIN[p], 1'b1, PIN[p], 3'b000, p == 2};
  endfunction
  function automatic logic [15:0] frame_of(input logic [7:0] d);
    return {6'h00, 1'b1, d, 1'b0};
  endfunction
  // comparisons and the closing report
  task automatic check_reg(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    check_reg({8'h00, g}, {8'h00, e});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    end_of_test();
  endtask
  // one register access; a read's data is taken in the following cycle
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= wr;
    regRd <= !wr;
    @(posedge core_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge core_clk);
    rd = regRdata;
    rd2 = regRdata2;
    @(posedge core_clk);
  endtask
  // party request held until its ready is sampled high
  task automatic party_send(input int i, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    txData[i] <= d;
    txValid[i] <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (txReady[i] !== 1'b1 && k < 2000);
    txValid[i] <= 1'b0;
    if (k >= 2000) hang();
  endtask
  // bench-made frame into the second device, stop level chosen
  task automatic raw_send(input logic [7:0] d, input logic stopBit);
    logic [9:0] fr;
    fr = {stopBit, d, 1'b0};
    for (int k = 0; k < 10; k++) begin
      link2.dedicatedRxd <= fr[k];
      repeat (BIT) @(posedge core_clk);
    end
    link2.dedicatedRxd <= 1'b1;
    repeat (BIT) @(posedge core_clk);
  endtask
  // sample one device frame at mid-bit straight off the wire
  task automatic grab(output logic [9:0] fr);
    int k;
    k = 0;
    while (link.dedicatedTxd !== 1'b0 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 2000) hang();
    repeat (BIT / 2) @(posedge core_clk);
    for (int j = 0; j < 10; j++) begin
      fr[j] = link.dedicatedTxd;
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(47));
    for (int i = 0; i < 4; i++) begin
      baudDiv[i] = div_of(i);
      txValid[i] = 1'b0;
      txData[i] = 8'h00;
      got[i] = 1'b0;
    end
    link2.gpioIn = 16'hffff;
    link2.dedicatedRxd = 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    // reset values, then an unmapped port
    for (int p = 0; p < 4; p++) begin
      bus(1'b0, ad(p, 2), 16'h0000);
      check_reg(rd, 16'h001b);
      bus(1'b0, ad(p, 1), 16'h0000);
      check_reg(rd, 16'h0001);
    end
    bus(1'b1, ad(5, 2), 16'h1234);
    bus(1'b0, ad(5, 2), 16'h0000);
    check_reg(rd, 16'h0000);
    bus(1'b0, ad(1, 2), 16'h0000);
    check_reg(rd, 16'h001b);
    // per-port rates and pin routing; dedicated port ignores routing
    for (int p = 0; p < 4; p++) bus(1'b1, ad(p, 2), div_of(p));
    for (int p = 1; p < 4; p++) bus(1'b1, ad(p, 3), ctrl_of(p));
    bus(1'b1, ad(0, 3), 16'h3ff0);
    check_reg(link.gpioOutEn_n, 16'hef7e);
    bus(1'b0, ad(0, 3), 16'h0000);
    check_reg(rd, 16'h0000);
    // download traffic stays off the registers
    v = 8'($urandom);
    party_send(0, v);
    n = 0;
    while (dlStrobe !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 1000) hang();
    check_byte(dlData, v);
    @(posedge core_clk);
    bus(1'b0, ad(0, 1), 16'h0000);
    check_reg(rd & 16'h0002, 16'h0000);
    // all ports both ways at once; a write to a busy port is dropped
    appRunning <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      c[i] = 8'($urandom);
      got[i] = 1'b0;
    end
    fork
      for (int i = 0; i < 4; i++) begin
        automatic int j = i;
        fork party_send(j, b[j]); join_none
      end
      begin
        // back-to-back write hits port 0 while still pending, so it is refused
        regAddr <= ad(0, 0);
        regWdata <= {8'h00, c[0]};
        regWr <= 1'b1;
        @(posedge core_clk);
        regWdata <= {8'h00, ~c[0]};
        @(posedge core_clk);
        for (int p = 1; p < 4; p++) bus(1'b1, ad(p, 0), {8'h00, c[p]});
      end
    join
    n = 0;
    while ((got[0] & got[1] & got[2] & got[3]) !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) hang();
    repeat (100) @(posedge core_clk);
    for (int p = 0; p < 4; p++) begin
      check_byte(gotData[p], c[p]);
      bus(1'b0, ad(p, 1), 16'h0000);
      check_reg(rd & 16'h0006, 16'h0002);
      bus(1'b0, ad(p, 0), 16'h0000);
      check_byte(rd[7:0], b[p]);
    end
    got[0] = 1'b0;
    repeat (400) @(posedge core_clk);
    check_reg({15'h0000, got[0]}, 16'h0000);
    // wire frames with corner data
    vals = '{8'h01, 8'h80, 8'($urandom)};
    foreach (vals[k]) begin
      bus(1'b1, ad(0, 0), {8'h00, vals[k]});
      grab(f);
      check_reg({6'h00, f}, frame_of(vals[k]));
    end
    // buffered port keeps both bytes, single-byte port overwrites
    for (int i = 0; i < 4; i++) b[i] = 8'($urandom);
    fork
      begin party_send(1, b[0]); party_send(1, b[1]); end
      begin party_send(2, b[2]); party_send(2, b[3]); end
    join
    repeat (400) @(posedge core_clk);
    bus(1'b0, ad(2, 0), 16'h0000);
    check_byte(rd[7:0], b[2]);
    bus(1'b0, ad(2, 0), 16'h0000);
    check_byte(rd[7:0], b[3]);
    bus(1'b0, ad(1, 1), 16'h0000);
    check_reg(rd & 16'h000a, 16'h000a);
    bus(1'b0, ad(1, 0), 16'h0000);
    check_byte(rd[7:0], b[1]);
    bus(1'b1, ad(1, 1), 16'h0008);
    bus(1'b0, ad(1, 1), 16'h0000);
    check_reg(rd & 16'h0008, 16'h0000);
    // bench frames: a good one, then one whose stop bit reads zero
    v = 8'($urandom);
    raw_send(v, 1'b1);
    bus(1'b0, ad(0, 0), 16'h0000);
    check_byte(rd2[7:0], v);
    raw_send(~v, 1'b0);
    bus(1'b0, ad(0, 1), 16'h0000);
    check_reg(rd2 & 16'h0004, 16'h0004);
    bus(1'b1, ad(0, 1), 16'h0004);
    bus(1'b0, ad(0, 1), 16'h0000);
    check_reg(rd2 & 16'h0004, 16'h0000);
    end_of_test();
  end
endmodule
